// File: design/dnwg_guard.sv
// data nvm write guard: control registers, unlock detector, array and fuse word
//
// Functional notes
// - power-on clears write_allow so no array write can follow power-up.
// - no array write starts while the power-up delay timer is counting.
// - array write starts only with completed unlock and write_allow set.
// - config bit 8 is the data lock fuse, zero means protected.
// - the core reads and writes the array normally while the fuse is active.
// - unimplemented address bit 7 and control bits 7..4 read zero.
// - control bits: abort 3, allow 2, write-go 1, read-go 0.
// - unlock port stores nothing, writes only feed the unlock detector.
// - config bits read zero when programmed, one when erased, word 2007h.
// - configuration space is reachable only in programming mode.
// - config bits 11 to 9 read as zero.
// - write-go ignored without write_allow; clearing allow keeps a started write.
// - write finish clears write-go and sets the sticky done flag.
// - abort flag set by a non-power reset cutting a write, cleared on normal finish.
`timescale 1ns/10ps
module dnwg_guard
   import dnwg_pkg::*;
#(
   parameter int DEPTH = 128,
   parameter int POWERUP_CYC = POWERUP_DELAY_CYC,
   parameter int WRITE_CYC = ARRAY_WRITE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire dnwg_pkg::dnwg_bus_req_s bus_req,
   output logic [7:0] bus_rdata,
   input wire dnwg_pkg::dnwg_cause_e reset_cause,
   input wire logic prog_mode,
   input wire dnwg_pkg::dnwg_prog_req_s prog_req,
   output logic [13:0] prog_rdata,
   output logic data_lock_active,
   output logic write_busy
);
   import dnwg_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {UNL_IDLE, UNL_KEY_ONE, UNL_ARMED} dnwg_unlock_e;

   logic [7:0] mem_r [DEPTH];
   logic [7:0] data_r, data_nxt;
   logic [6:0] addr_r;
   logic allow_r, allow_nxt;
   logic go_r, go_nxt;
   logic abort_r, abort_nxt;
   logic done_r, done_nxt;
   logic [4:0] pflags_r;
   logic [31:0] pwrup_cnt_r;
   logic [31:0] wr_cnt_r;
   logic [6:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic [13:0] cfg_r;
   logic [7:0] bus_rdata_r;
   logic [13:0] prog_rdata_r;
   dnwg_unlock_e unl_r, unl_nxt;
   logic wr_busy_r;
   logic cause_taken_r;
   logic cut_pending_r;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire sel_flags = bus_req.addr == ADDR_PERIPHERAL_FLAGS_ONE;
   wire sel_data = bus_req.addr == ADDR_NVM_DATA_BYTE;
   wire sel_addr = bus_req.addr == ADDR_NVM_BYTE_ADDRESS;
   wire sel_ctl = bus_req.addr == ADDR_NVM_CONTROL;
   wire sel_unl = bus_req.addr == ADDR_NVM_UNLOCK_PORT;
   wire any_acc = bus_req.wr | bus_req.rd;
   wire unl_wr = bus_req.wr & sel_unl;
   wire ctl_wr = bus_req.wr & sel_ctl;
   wire pwrup_busy = pwrup_cnt_r != 32'd0;
   wire wr_fin = wr_busy_r && wr_cnt_r == 32'd1;
   // write-go request: needs allow already set in allow_r; allow written in the same access does not count
   wire go_req = ctl_wr & bus_req.wdata[CTL_WRITE_GO] & ~go_r;
   wire allow_in = ctl_wr ? bus_req.wdata[CTL_WRITE_ALLOW] : allow_r;
   wire start_wr = go_req & allow_r & (unl_r == UNL_ARMED) & ~pwrup_busy;
   wire wr_busy_nxt = start_wr | (wr_busy_r & ~wr_fin);
   wire rd_go = ctl_wr & bus_req.wdata[CTL_READ_GO];
   wire [7:0] ctl_view = {4'h0, abort_r, allow_r, go_r, 1'b0} & CTL_IMPL_MASK;
   wire [7:0] flags_view = {done_r, pflags_r[4], 2'b00, pflags_r[3], 2'b00, pflags_r[0]};
   wire in_cfg_space = prog_mode && prog_req.addr >= ADDR_CONFIG_LO;
   wire cfg_sel = in_cfg_space && prog_req.addr == ADDR_CONFIG_WORD;
   wire data_locked = ~cfg_r[CFG_DATA_LOCK];
   // a write still running when a non-power reset hit is reported once released
   wire cut_seen = rstn && !cause_taken_r && cut_pending_r
      && reset_cause != RESET_POWER_ON;

   // ----------------------------------------
   // unlock detector
   // ----------------------------------------
   // any access other than the exact next step throws progress away
   always_comb begin
      unl_nxt = unl_r;
      case (unl_r)
         UNL_IDLE: begin
            if (unl_wr && bus_req.wdata == UNLOCK_KEY_ONE) begin
               unl_nxt = UNL_KEY_ONE;
            end
         end
         UNL_KEY_ONE: begin
            if (unl_wr && bus_req.wdata == UNLOCK_KEY_TWO) begin
               unl_nxt = UNL_ARMED;
            end else if (any_acc) begin
               unl_nxt = UNL_IDLE;
            end
         end
         UNL_ARMED: begin
            if (any_acc) begin
               unl_nxt = UNL_IDLE;
            end
         end
         default: unl_nxt = UNL_IDLE;
      endcase
   end

   // ----------------------------------------
   // control and flag next values
   // ----------------------------------------
   always_comb begin
      allow_nxt = allow_in;
      go_nxt = go_r;
      abort_nxt = abort_r;
      done_nxt = done_r;
      data_nxt = data_r;
      if (start_wr) begin
         go_nxt = 1'b1;
      end
      if (wr_fin) begin
         go_nxt = 1'b0;
         abort_nxt = 1'b0;
      end else if (ctl_wr) begin
         abort_nxt = bus_req.wdata[CTL_WRITE_ABORT];
      end
      if (cut_seen) begin
         abort_nxt = 1'b1;
      end
      // done flag: hardware set wins over software clear
      if (bus_req.wr && sel_flags) begin
         done_nxt = bus_req.wdata[FLAGS_NVM_DONE];
      end
      if (wr_fin) begin
         done_nxt = 1'b1;
      end
      if (bus_req.wr && sel_data) begin
         data_nxt = bus_req.wdata;
      end
      if (rd_go) begin
         data_nxt = mem_r[addr_r];
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // every reset clears allow; a write cut by a non-power reset reports abort after release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         allow_r <= 1'b0;
         go_r <= 1'b0;
         unl_r <= UNL_IDLE;
         done_r <= 1'b0;
         data_r <= RST_BYTE;
         addr_r <= 7'h00;
         pflags_r <= 5'h00;
         abort_r <= 1'b0;
         wr_busy_r <= 1'b0;
      end else begin
         allow_r <= allow_nxt;
         go_r <= go_nxt;
         unl_r <= unl_nxt;
         done_r <= done_nxt;
         data_r <= data_nxt;
         if (bus_req.wr && sel_addr) begin
            addr_r <= bus_req.wdata[6:0];
         end
         if (bus_req.wr && sel_flags) begin
            pflags_r <= {bus_req.wdata[6], bus_req.wdata[3], 2'b00, bus_req.wdata[0]};
         end
         abort_r <= abort_nxt;
         wr_busy_r <= wr_busy_nxt;
      end
   end

   // reset cause is sampled on the first clock after release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cause_taken_r <= 1'b0;
      end else begin
         cause_taken_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // write-in-progress record survives non-power resets
   // ----------------------------------------
   // kept outside reset and frozen while reset is low, so a cut write is known afterwards
   always_ff @(posedge clk) begin
      if (rstn) begin
         cut_pending_r <= wr_busy_nxt;
      end
   end

   // ----------------------------------------
   // timers
   // ----------------------------------------
   // power-up delay runs after power-on only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwrup_cnt_r <= 32'd0;
         wr_cnt_r <= 32'd0;
      end else begin
         if (!cause_taken_r && reset_cause == RESET_POWER_ON) begin
            pwrup_cnt_r <= 32'(POWERUP_CYC);
         end else if (pwrup_busy) begin
            pwrup_cnt_r <= pwrup_cnt_r - 32'd1;
         end
         if (start_wr) begin
            wr_cnt_r <= 32'(WRITE_CYC);
         end else if (wr_busy_r) begin
            wr_cnt_r <= wr_cnt_r - 32'd1;
         end
      end
   end

   // ----------------------------------------
   // array and latched write operands
   // ----------------------------------------
   // operands latched at start so later register writes cannot corrupt it
   always_ff @(posedge clk) begin
      if (start_wr) begin
         wr_addr_r <= addr_r;
         wr_data_r <= data_r;
      end
      if (wr_fin) begin
         mem_r[wr_addr_r] <= wr_data_r;
      end
   end

   // ----------------------------------------
   // fuse word, programming mode only
   // ----------------------------------------
   // erased word reads all ones except unimplemented bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r <= CFG_ERASED & ~CFG_UNIMPL_MASK;
         prog_rdata_r <= 14'h0000;
      end else begin
         if (cfg_sel && prog_req.wr) begin
            cfg_r <= prog_req.wdata & ~CFG_UNIMPL_MASK;
         end
         if (cfg_sel && prog_req.rd) begin
            prog_rdata_r <= cfg_r;
         end else if (prog_req.rd && !in_cfg_space && data_locked && prog_mode) begin
            prog_rdata_r <= 14'h0000;
         end else begin
            prog_rdata_r <= 14'h0000;
         end
      end
   end

   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_rdata_r <= 8'h00;
      end else if (bus_req.rd) begin
         bus_rdata_r <= sel_flags ? flags_view :
            sel_data ? data_r :
            sel_addr ? {1'b0, addr_r} & ADDR_IMPL_MASK :
            sel_ctl ? (ctl_view | {4'h0, cut_seen, 3'b000}) : 8'h00;
      end else begin
         bus_rdata_r <= 8'h00;
      end
   end

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   logic lock_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_r <= 1'b0;
      end else begin
         lock_r <= data_locked;
      end
   end

   assign bus_rdata = bus_rdata_r;
   assign prog_rdata = prog_rdata_r;
   assign data_lock_active = lock_r;
   assign write_busy = wr_busy_r;

endmodule

// File: design/dnwg_pkg.sv
// package: register map, field positions, timing and carrier types for the data nvm guard
package dnwg_pkg;
   // ----------------------------------------
   // register offsets (file register addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_PERIPHERAL_FLAGS_ONE = 8'h0c;
   localparam logic [7:0] ADDR_NVM_DATA_BYTE = 8'h9a;
   localparam logic [7:0] ADDR_NVM_BYTE_ADDRESS = 8'h9b;
   localparam logic [7:0] ADDR_NVM_CONTROL = 8'h9c;
   localparam logic [7:0] ADDR_NVM_UNLOCK_PORT = 8'h9d;
   // configuration word location and space
   localparam logic [13:0] ADDR_CONFIG_WORD = 14'h2007;
   localparam logic [13:0] ADDR_CONFIG_LO = 14'h2000;
   localparam logic [13:0] ADDR_CONFIG_HI = 14'h3fff;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTL_READ_GO = 0;
   localparam int CTL_WRITE_GO = 1;
   localparam int CTL_WRITE_ALLOW = 2;
   localparam int CTL_WRITE_ABORT = 3;
   localparam int FLAGS_NVM_DONE = 7;
   localparam int CFG_CODE_LOCK = 7;
   localparam int CFG_DATA_LOCK = 8;
   localparam logic [13:0] CFG_UNIMPL_MASK = 14'h0e00;
   localparam logic [7:0] ADDR_IMPL_MASK = 8'h7f;
   localparam logic [7:0] CTL_IMPL_MASK = 8'h0f;
   localparam logic [7:0] FLAGS_IMPL_MASK = 8'hc9;
   // ----------------------------------------
   // reset values and unlock keys
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [13:0] CFG_ERASED = 14'h3fff;
   localparam logic [7:0] UNLOCK_KEY_ONE = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_TWO = 8'haa;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int POWERUP_DELAY_MS = 72;
   localparam int POWERUP_DELAY_CYC = POWERUP_DELAY_MS * (CLK_HZ / 1000);
   localparam int ARRAY_WRITE_US = 4000;
   localparam int ARRAY_WRITE_CYC = ARRAY_WRITE_US * (CLK_HZ / 1_000_000);
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dnwg_bus_req_s;
   typedef struct packed {
      logic [13:0] addr;
      logic [13:0] wdata;
      logic wr;
      logic rd;
   } dnwg_prog_req_s;
   typedef enum logic [1:0] {
      RESET_POWER_ON,
      RESET_EXTERNAL,
      RESET_WATCHDOG,
      RESET_BROWNOUT
   } dnwg_cause_e;
endpackage

// File: tb/dnwg_cpu_model.sv
// cpu core model driving the guard register bus
`timescale 1ns/10ps
module dnwg_cpu_model (
   input wire logic clk,
   output dnwg_pkg::dnwg_bus_req_s bus_req,
   input wire logic [7:0] bus_rdata
);
   import dnwg_pkg::*;
   // ----
   // bus cycles
   // ----
   initial bus_req = '0;
   // strobe one cycle then idle, so no signal is driven twice in one step
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge clk);
      bus_req <= '{a, d, w, !w};
      @(posedge clk);
      bus_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, d);
      acc(1'b1, a, d);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      acc(1'b0, a, 8'h00);
      #1 d = bus_rdata;
   endtask
   // two keys as consecutive accesses, then control byte c
   task automatic unlock(input logic [7:0] c);
      wr(ADDR_NVM_UNLOCK_PORT, UNLOCK_KEY_ONE);
      wr(ADDR_NVM_UNLOCK_PORT, UNLOCK_KEY_TWO);
      wr(ADDR_NVM_CONTROL, c);
   endtask
endmodule

// File: tb/dnwg_guard_properties.sv
// checker: port relations of the data nvm write guard
`timescale 1ns/10ps
module dnwg_guard_properties #(
   parameter int POWERUP_CYC = 20,
   parameter int WRITE_CYC = 10
) (
   input wire logic clk,
   input wire logic rstn,
   input wire dnwg_pkg::dnwg_bus_req_s bus_req,
   input wire logic [7:0] bus_rdata,
   input wire dnwg_pkg::dnwg_cause_e reset_cause,
   input wire logic prog_mode,
   input wire dnwg_pkg::dnwg_prog_req_s prog_req,
   input wire logic [13:0] prog_rdata,
   input wire logic data_lock_active,
   input wire logic write_busy
);
   import dnwg_pkg::*;
   // ----
   // helpers
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   int pu_cnt_r;
   int busy_cnt_r;
   wire go_req = bus_req.wr && bus_req.addr == ADDR_NVM_CONTROL && bus_req.wdata[CTL_WRITE_GO];
   // cycles since release, and length of the running write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pu_cnt_r <= 0;
         busy_cnt_r <= 0;
      end else begin
         pu_cnt_r <= (pu_cnt_r < POWERUP_CYC) ? pu_cnt_r + 1 : pu_cnt_r;
         busy_cnt_r <= write_busy ? busy_cnt_r + 1 : 0;
      end
   end
   sequence s_fuse_wr;
      prog_mode && prog_req.wr && prog_req.addr == ADDR_CONFIG_WORD;
   endsequence
   property p_fuse_map;
      s_fuse_wr |-> ##2 (data_lock_active == !$past(prog_req.wdata[CFG_DATA_LOCK], 2));
   endproperty
   a_fuse_map: assert property (p_fuse_map) else $error("lock out wrong");
   property p_fuse_hold;
      !prog_mode && !$past(prog_mode) && $past(rstn, 2) |=> $stable(data_lock_active);
   endproperty
   a_fuse_hold: assert property (p_fuse_hold) else $error("lock moved");
   property p_unlock_rd;
      bus_req.rd && bus_req.addr == ADDR_NVM_UNLOCK_PORT |=> bus_rdata == 8'h00;
   endproperty
   a_unlock_rd: assert property (p_unlock_rd) else $error("unlock port read");
   property p_ctl_hi;
      bus_req.rd && bus_req.addr == ADDR_NVM_CONTROL |=> bus_rdata[7:4] == 4'h0;
   endproperty
   a_ctl_hi: assert property (p_ctl_hi) else $error("control high bits");
   property p_adr_hi;
      bus_req.rd && bus_req.addr == ADDR_NVM_BYTE_ADDRESS |=> !bus_rdata[7];
   endproperty
   a_adr_hi: assert property (p_adr_hi) else $error("address bit 7");
   property p_cfg_gap;
      prog_req.rd |=> prog_rdata[11:9] == 3'h0;
   endproperty
   a_cfg_gap: assert property (p_cfg_gap) else $error("config gap bits");
   property p_pu_block;
      reset_cause == RESET_POWER_ON && pu_cnt_r < POWERUP_CYC - 2 |-> !write_busy;
   endproperty
   a_pu_block: assert property (p_pu_block) else $error("write in delay");
   property p_busy_cause;
      $rose(write_busy) |-> $past(go_req) || $past(go_req, 2);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("write w/o go");
   property p_busy_len;
      $fell(write_busy) |-> busy_cnt_r inside {[WRITE_CYC - 1:WRITE_CYC + 1]};
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("write length");
endmodule
bind dnwg_guard dnwg_guard_properties #(.POWERUP_CYC(POWERUP_CYC), .WRITE_CYC(WRITE_CYC))
   u_props (.clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .reset_cause(reset_cause), .prog_mode(prog_mode), .prog_req(prog_req),
   .prog_rdata(prog_rdata), .data_lock_active(data_lock_active), .write_busy(write_busy));

// File: tb/dnwg_guard_tb_top.sv
// self-checking bench for the data nvm write guard
`timescale 1ns/10ps
module dnwg_guard_tb_top;
   import dnwg_pkg::*;
   localparam int PU = 20;
   logic clk, rstn, prog_mode, data_lock_active, write_busy, seen_busy;
   logic [7:0] bus_rdata, v;
   logic [13:0] prog_rdata;
   dnwg_bus_req_s bus_req;
   dnwg_prog_req_s prog_req;
   dnwg_cause_e reset_cause;
   int failures, samples_checked;
   dnwg_cpu_model cpu (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata));
   dnwg_guard #(.POWERUP_CYC(PU), .WRITE_CYC(10)) dut (.clk(clk), .rstn(rstn),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .reset_cause(reset_cause),
      .prog_mode(prog_mode), .prog_req(prog_req), .prog_rdata(prog_rdata),
      .data_lock_active(data_lock_active), .write_busy(write_busy));
   // ----
   // clock, tasks
   // ----
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // a short spurious write is remembered for the rest of the run
   always @(posedge clk) if (write_busy === 1'b1) seen_busy <= 1'b1;
   task automatic chk(input string n, input logic [13:0] e, g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, m, e);
      cpu.rd(a, v);
      chk(n, 14'(e), 14'(v & m));
   endtask
   task automatic pacc(input logic w, input logic [13:0] d);
      @(posedge clk);
      prog_req <= '{ADDR_CONFIG_WORD, d, w, !w};
      @(posedge clk);
      prog_req <= '0;
      #1;
   endtask
   task automatic results();
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // bounded wait on the write flag; running out ends the run
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (write_busy !== lvl && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (n == 100) begin
         failures++;
         results();
      end
   endtask
   // ----
   // scenarios
   // ----
   initial begin
      rstn = 1'b0;
      prog_mode = 1'b0;
      prog_req = '0;
      reset_cause = RESET_POWER_ON;
      seen_busy = 1'b0;
      failures = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rchk("ctl_por", ADDR_NVM_CONTROL, 8'hf7, 8'h00);
      cpu.wr(ADDR_NVM_CONTROL, 8'h04);
      cpu.unlock(8'h06);
      repeat (3) @(posedge clk);
      chk("busy_pu", 14'h0, 14'(seen_busy));
      rchk("ctl_pu", ADDR_NVM_CONTROL, 8'hf7, 8'h04);
      repeat (PU) @(posedge clk);
      prog_mode <= 1'b1;
      pacc(1'b1, 14'h3e7f);
      pacc(1'b0, 14'h0);
      chk("cfg", 14'h307f, prog_rdata);
      chk("lock", 14'h1, 14'(data_lock_active));
      @(posedge clk);
      prog_mode <= 1'b0;
      pacc(1'b1, 14'h3fff);
      @(posedge clk);
      prog_mode <= 1'b1;
      pacc(1'b0, 14'h0);
      chk("cfg_kept", 14'h307f, prog_rdata);
      @(posedge clk);
      prog_mode <= 1'b0;
      cpu.wr(ADDR_NVM_BYTE_ADDRESS, 8'hff);
      rchk("adr", ADDR_NVM_BYTE_ADDRESS, 8'hff, 8'h7f);
      cpu.wr(ADDR_NVM_DATA_BYTE, 8'h5a);
      cpu.wr(ADDR_NVM_CONTROL, 8'h06);
      cpu.wr(8'h50, 8'hff);
      rchk("unmapped", 8'h50, 8'hff, 8'h00);
      rchk("unlock_rd", ADDR_NVM_UNLOCK_PORT, 8'hff, 8'h00);
      cpu.wr(ADDR_NVM_UNLOCK_PORT, UNLOCK_KEY_ONE);
      rchk("data", ADDR_NVM_DATA_BYTE, 8'hff, 8'h5a);
      cpu.wr(ADDR_NVM_UNLOCK_PORT, UNLOCK_KEY_TWO);
      cpu.wr(ADDR_NVM_CONTROL, 8'h06);
      cpu.wr(ADDR_NVM_CONTROL, 8'h00);
      cpu.unlock(8'h02);
      chk("no_write", 14'h0, 14'(seen_busy));
      cpu.wr(ADDR_NVM_CONTROL, 8'h04);
      cpu.unlock(8'h06);
      wait_busy(1'b1);
      cpu.wr(ADDR_NVM_CONTROL, 8'h00);
      wait_busy(1'b0);
      rchk("done", ADDR_PERIPHERAL_FLAGS_ONE, 8'h80, 8'h80);
      rchk("ctl_end", ADDR_NVM_CONTROL, 8'hff, 8'h00);
      cpu.wr(ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
      rchk("done_clr", ADDR_PERIPHERAL_FLAGS_ONE, 8'h80, 8'h00);
      cpu.wr(ADDR_NVM_DATA_BYTE, 8'h00);
      cpu.wr(ADDR_NVM_CONTROL, 8'h01);
      rchk("readback", ADDR_NVM_DATA_BYTE, 8'hff, 8'h5a);
      for (int i = 1; i < 4; i++) begin
         cpu.wr(ADDR_NVM_CONTROL, 8'h04);
         cpu.unlock(8'h06);
         wait_busy(1'b1);
         @(posedge clk);
         reset_cause <= dnwg_cause_e'(i);
         rstn <= 1'b0;
         repeat (2) @(posedge clk);
         rstn <= 1'b1;
         rchk("abort", ADDR_NVM_CONTROL, 8'hff, 8'h08);
      end
      cpu.wr(ADDR_NVM_CONTROL, 8'h0c);
      cpu.unlock(8'h0e);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rchk("abort_clr", ADDR_NVM_CONTROL, 8'hff, 8'h04);
      results();
   end
endmodule
